// ---- logic/usbh_map.svh ----
// Register offsets, field positions, reset values and timing counts of the hub control block
`ifndef USBH_MAP_SVH
`define USBH_MAP_SVH
// Byte offsets on the register bus
`define USBH_OFF_TIMING_STATUS   8'h00
`define USBH_OFF_FUNC_ADDRESS    8'h04
`define USBH_OFF_EP0_INTERRUPT   8'h08
`define USBH_OFF_EP0_CONTROL     8'h0c
`define USBH_OFF_EP1_REPORT      8'h10
// Timing status: flag and its write-one clear share a position
`define USBH_TS_BUS_RESET        7
`define USBH_TS_FRAME_LOCK       6
`define USBH_TS_FRAME_EVT_LSB    0
// Function address
`define USBH_HA_ENABLE           7
// Endpoint 0 interrupt register
`define USBH_I0_TX_DONE          7
`define USBH_I0_RX_DONE          6
`define USBH_I0_TX_IE            3
`define USBH_I0_RX_IE            2
`define USBH_I0_TX_CLR           1
`define USBH_I0_RX_CLR           0
// Endpoint 0 control register
`define USBH_C0_TOGGLE           7
`define USBH_C0_STALL            6
`define USBH_C0_TX_EN            5
`define USBH_C0_RX_EN            4
// Endpoint 1 report register
`define USBH_C1_STALL            7
`define USBH_C1_PENDING          6
// Reset values
`define USBH_RST_BYTE            8'h00
`define USBH_RST_ADDR            7'h00
`define USBH_RST_COUNT           4'h0
`define USBH_RST_BITMAP          6'h00
`define USBH_EP1_REPORT_BYTES    4'h1
// Line timing: least SE0 time that counts as a bus reset
`define USBH_CLK_PERIOD_NS       100
`define USBH_RST_SE0_NS          2500
`define USBH_RST_SE0_CYC         ((`USBH_RST_SE0_NS + `USBH_CLK_PERIOD_NS - 1) / `USBH_CLK_PERIOD_NS)
`define USBH_RST_CNT_W           5
`endif

// ---- logic/usbh_pkg.sv ----
// Types shared by the hub control block
package usbh_pkg;
    typedef enum logic [1:0] {
        TOK_OUT   = 2'b00,
        TOK_IN    = 2'b01,
        TOK_SETUP = 2'b10,
        TOK_SOF   = 2'b11
    } usbh_tok_t;

    typedef enum logic [2:0] {
        RSP_NONE  = 3'b000,
        RSP_DATA  = 3'b001,
        RSP_ACK   = 3'b010,
        RSP_NAK   = 3'b011,
        RSP_STALL = 3'b100
    } usbh_rsp_t;
endpackage

// ---- logic/usbh_line_sync.sv ----
// Root port line synchroniser with bus reset and transition detection
`include "usbh_map.svh"
module usbh_line_sync (
    // Clock and control
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_ce,
    // Root port pins
    input  wire logic i_dp,
    input  wire logic i_dm,
    // Events
    output logic      o_bus_reset,
    output logic      o_transition
);
    logic [1:0]                 s1_q;
    logic [1:0]                 s2_q;
    logic [1:0]                 s3_q;
    logic [1:0]                 line_q;
    logic [`USBH_RST_CNT_W-1:0] se0_cnt_q;
    logic                       rst_evt_q;
    logic                       tran_q;
    logic [1:0]                 agree;
    logic [1:0]                 line_d;
    logic                       se0;
    logic                       cnt_top;

    // A bit moves only once the second and third stages agree
    assign agree   = ~(s2_q ^ s3_q);
    assign line_d  = (agree & s3_q) | (~agree & line_q);
    assign se0     = (line_q == 2'b00);
    assign cnt_top = (se0_cnt_q == `USBH_RST_CNT_W'(`USBH_RST_SE0_CYC));

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s1_q      <= 2'b10;
            s2_q      <= 2'b10;
            s3_q      <= 2'b10;
            line_q    <= 2'b10;
            se0_cnt_q <= '0;
            rst_evt_q <= 1'b0;
            tran_q    <= 1'b0;
        end else if (i_ce) begin
            s1_q      <= {i_dp, i_dm};
            s2_q      <= s1_q;
            s3_q      <= s2_q;
            line_q    <= line_d;
            tran_q    <= (line_d != line_q);
            se0_cnt_q <= !se0 ? '0 : (cnt_top ? se0_cnt_q : se0_cnt_q + 1'b1);
            rst_evt_q <= se0 && (se0_cnt_q == `USBH_RST_CNT_W'(`USBH_RST_SE0_CYC - 1));
        end
    end

    assign o_bus_reset  = rst_evt_q;
    assign o_transition = tran_q;
endmodule

// ---- logic/usbh_ep_resp.sv ----
// Handshake selection for hub endpoint 0 and endpoint 1 tokens
module usbh_ep_resp
    import usbh_pkg::*;
(
    // Clock and control
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    // Token addressed to this hub
    input  wire logic       i_hit0,
    input  wire logic       i_hit1,
    input  wire logic [1:0] i_tok,
    // Endpoint state
    input  wire logic       i_ep0_force_stall,
    input  wire logic       i_tx_en,
    input  wire logic       i_tx_done,
    input  wire logic       i_rx_en,
    input  wire logic       i_rx_done,
    input  wire logic       i_ep1_force_stall,
    input  wire logic       i_pending,
    // Response
    output logic            o_valid,
    output usbh_rsp_t       o_rsp,
    output logic            o_ep1
);
    usbh_rsp_t rsp0;
    usbh_rsp_t rsp1;
    usbh_rsp_t rsp_d;
    logic      tok_in;
    logic      tok_out;

    assign tok_in  = (i_tok == TOK_IN);
    assign tok_out = (i_tok == TOK_OUT);
    // Stall outranks the not-ready answer
    assign rsp0 = (i_tok == TOK_SETUP)          ? RSP_ACK   :
                  i_ep0_force_stall && (tok_in || tok_out) ? RSP_STALL : // [RL15] [RL21]
                  tok_in  ? ((!i_tx_en || i_tx_done) ? RSP_NAK : RSP_DATA) : // [RL9]
                  tok_out ? ((!i_rx_en || i_rx_done) ? RSP_NAK : RSP_ACK)  : // [RL11]
                  RSP_NONE;
    assign rsp1 = !tok_in  ? RSP_NONE  :
                  i_ep1_force_stall ? RSP_STALL :  // [RL17] [RL21]
                  i_pending ? RSP_DATA : RSP_NAK; // [RL18]
    assign rsp_d = i_hit0 ? rsp0 : (i_hit1 ? rsp1 : RSP_NONE);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_valid <= 1'b0;
            o_rsp   <= RSP_NONE;
            o_ep1   <= 1'b0;
        end else if (i_ce) begin
            o_valid <= (rsp_d != RSP_NONE);
            o_rsp   <= rsp_d;
            o_ep1   <= i_hit1;
        end
    end
endmodule

// ---- logic/usbh_ep_ctrl.sv ----
// Hub status and control registers with endpoint 0/1 token answering
//
// Added by the designer: register access over Wishbone and the register offsets.
`include "usbh_map.svh"
// Summary of operation
// (RL1) Detected bus reset sets the reset flag and requests a chip-wide reset.
// (RL2) Reset flag cleared only by power-on reset or a write-one clear.
// (RL3) Each clear bit clears its flag on a one, ignores a zero.
// (RL4) Frame lock event sets the lock flag; reset or clear bit removes it.
// (RL5) Module disabled: no token answers, regulator and transceiver off.
// (RL6) Module enable, once set, stays set until power-on reset.
// (RL7) Seven-bit hub address picks tokens to answer; reset zeroes it.
// (RL8) Endpoint 0 transmit-done sets after data sent and host ACK seen.
// (RL9) Endpoint 0 IN gets NAK if transmit disabled or transmit-done set.
// (RL10) Endpoint 0 receive-done sets after a packet is accepted and ACKed.
// (RL11) Endpoint 0 OUT gets NAK if receive disabled or receive-done set.
// (RL12) Software clears done flags and re-enables only after servicing data.
// (RL13) Done flags with their enables raise the CPU interrupt request.
// (RL14) Software-held toggle picks DATA1 or DATA0; hardware never changes it.
// (RL15) Endpoint 0 stall answers IN and OUT; SETUP clears the stall bit.
// (RL16) Four-bit transmit count goes with the next endpoint 0 IN; reset clears.
// (RL17) Endpoint 1 stall bit answers endpoint 1 polls with STALL.
// (RL18) Endpoint 1 IN sends the bitmap when pending is set, else NAK.
// (RL19) Six-bit change bitmap: hub, ports 1-4, embedded device; reset clears.
// (RL20) Valid SOF sets the frame start flag until its clear bit.
// (RL21) Stall wins over NAK when both conditions hold.
module usbh_ep_ctrl
    import usbh_pkg::*;
(
    // Clock, enable and resets
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic        i_por,
    input  wire logic        i_ce,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    // Root port pins
    input  wire logic        i_dp,
    input  wire logic        i_dm,
    // Decoded token and bus events from the serial engine
    input  wire logic        i_tok_valid,
    input  wire logic [1:0]  i_tok_pid,
    input  wire logic [6:0]  i_tok_addr,
    input  wire logic [3:0]  i_tok_ep,
    input  wire logic        i_ep0_tx_acked,
    input  wire logic        i_ep0_rx_accepted,
    input  wire logic        i_frame_locked,
    input  wire logic        i_eof2_evt,
    input  wire logic        i_eop_evt,
    // Answer to the serial engine
    output logic             o_rsp_valid,
    output usbh_rsp_t        o_rsp,
    output logic             o_rsp_data1,
    output logic [3:0]       o_rsp_bytes,
    output logic [5:0]       o_change_bitmap,
    // Chip side
    output logic             o_chip_reset,
    output logic             o_regulator_en,
    output logic             o_xcvr_en,
    output logic             o_irq
);
    logic       ack_q;
    logic [7:0] rdat_q;
    logic       bus_reset_flag_q;
    logic       frame_lock_flag_q;
    logic [3:0] frame_evt_flag_q;
    logic       module_enable_q;
    logic [6:0] hub_address_q;
    logic       tx_done_q;
    logic       rx_done_q;
    logic       tx_ie_q;
    logic       rx_ie_q;
    logic       tx_toggle_q;
    logic       ep0_force_stall_q;
    logic       tx_en_q;
    logic       rx_en_q;
    logic [3:0] tx_bytes_q;
    logic       ep1_force_stall_q;
    logic       pending_q;
    logic [5:0] bitmap_q;
    logic       chip_reset_q;
    logic       enable_out_q;
    logic       irq_q;

    logic       bus_reset_evt;
    logic       transition_evt;
    logic       mod_rst;
    logic       rsp_ep1;
    logic       wr_fire;
    logic       wr_ts;
    logic       wr_ha;
    logic       wr_i0;
    logic       wr_c0;
    logic       wr_c1;
    logic [7:0] wd;
    logic [7:0] rd_mux;
    logic       ack_d;
    logic       tok_ok;
    logic       hit0;
    logic       hit1;
    logic       setup_hit;
    logic [3:0] frame_evt;
    logic [3:0] frame_clr;

    function automatic logic reg_at(input logic [7:0] adr, input logic [7:0] off);
        reg_at = (adr[7:2] == off[7:2]);
    endfunction

    usbh_line_sync u_line (
        .i_clk_sys    (i_clk_sys),
        .i_rst        (i_sys_rst | i_por),
        .i_ce         (i_ce),
        .i_dp         (i_dp),
        .i_dm         (i_dm),
        .o_bus_reset  (bus_reset_evt),
        .o_transition (transition_evt)
    );

    // The detected bus reset also resets this block's status flags, control fields and response stage
    assign mod_rst = i_sys_rst | i_por | bus_reset_evt; // [RL1]

    // Wishbone: one wait state, write lands on the acknowledged edge
    assign ack_d   = i_wb_cyc && i_wb_stb && !ack_q;
    assign wr_fire = ack_q && i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0];
    assign wd      = i_wb_dat[7:0];
    assign wr_ts   = wr_fire && reg_at(i_wb_adr, `USBH_OFF_TIMING_STATUS);
    assign wr_ha   = wr_fire && reg_at(i_wb_adr, `USBH_OFF_FUNC_ADDRESS);
    assign wr_i0   = wr_fire && reg_at(i_wb_adr, `USBH_OFF_EP0_INTERRUPT);
    assign wr_c0   = wr_fire && reg_at(i_wb_adr, `USBH_OFF_EP0_CONTROL);
    assign wr_c1   = wr_fire && reg_at(i_wb_adr, `USBH_OFF_EP1_REPORT);

    // Endpoint 0 interrupt clear bits are write-only and read back as zero; timing status clear bits read back their flags
    assign rd_mux =
        reg_at(i_wb_adr, `USBH_OFF_TIMING_STATUS) ?
            {bus_reset_flag_q, frame_lock_flag_q, 2'b00, frame_evt_flag_q} :
        reg_at(i_wb_adr, `USBH_OFF_FUNC_ADDRESS)  ? {module_enable_q, hub_address_q} :
        reg_at(i_wb_adr, `USBH_OFF_EP0_INTERRUPT) ?
            {tx_done_q, rx_done_q, 2'b00, tx_ie_q, rx_ie_q, 2'b00} :
        reg_at(i_wb_adr, `USBH_OFF_EP0_CONTROL)   ?
            {tx_toggle_q, ep0_force_stall_q, tx_en_q, rx_en_q, tx_bytes_q} :
        reg_at(i_wb_adr, `USBH_OFF_EP1_REPORT)    ? {ep1_force_stall_q, pending_q, bitmap_q} :
        `USBH_RST_BYTE;

    // Token qualification
    assign tok_ok    = i_tok_valid && module_enable_q; // [RL5]
    assign hit0      = tok_ok && (i_tok_addr == hub_address_q) && (i_tok_ep == 4'h0); // [RL7]
    assign hit1      = tok_ok && (i_tok_addr == hub_address_q) && (i_tok_ep == 4'h1);
    assign setup_hit = hit0 && (i_tok_pid == TOK_SETUP);

    // Frame events: start of frame, EOF2 point, end of packet, line transition
    assign frame_evt = {tok_ok && (i_tok_pid == TOK_SOF), i_eof2_evt, i_eop_evt, transition_evt};
    assign frame_clr = {4{wr_ts}} & wd[`USBH_TS_FRAME_EVT_LSB +: 4];

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst | i_por) begin
            ack_q  <= 1'b0;
            rdat_q <= `USBH_RST_BYTE;
        end else if (i_ce) begin
            ack_q  <= ack_d;
            rdat_q <= ack_d ? rd_mux : rdat_q;
        end
    end

    // Survives all resets but power-on; a new bus reset beats a clear
    always_ff @(posedge i_clk_sys) begin
        if (i_por) begin
            bus_reset_flag_q <= 1'b0;
            module_enable_q  <= 1'b0;
        end else if (i_ce) begin
            bus_reset_flag_q <= bus_reset_evt ||
                (bus_reset_flag_q && !(wr_ts && wd[`USBH_TS_BUS_RESET])); // [RL1] [RL2] [RL3]
            module_enable_q  <= module_enable_q || (wr_ha && wd[`USBH_HA_ENABLE]); // [RL6]
        end
    end

    // Status flags: a set in the clearing cycle wins
    always_ff @(posedge i_clk_sys) begin
        if (mod_rst) begin
            frame_lock_flag_q <= 1'b0;
            frame_evt_flag_q  <= 4'h0;
            tx_done_q         <= 1'b0;
            rx_done_q         <= 1'b0;
        end else if (i_ce) begin
            frame_lock_flag_q <= i_frame_locked ||
                (frame_lock_flag_q && !(wr_ts && wd[`USBH_TS_FRAME_LOCK])); // [RL4] [RL3]
            frame_evt_flag_q  <= frame_evt | (frame_evt_flag_q & ~frame_clr); // [RL20] [RL3]
            tx_done_q <= i_ep0_tx_acked ||
                (tx_done_q && !(wr_i0 && wd[`USBH_I0_TX_CLR])); // [RL8] [RL3]
            rx_done_q <= i_ep0_rx_accepted ||
                (rx_done_q && !(wr_i0 && wd[`USBH_I0_RX_CLR])); // [RL10] [RL3]
        end
    end

    // Software-owned control fields
    always_ff @(posedge i_clk_sys) begin
        if (mod_rst) begin
            hub_address_q <= `USBH_RST_ADDR; // [RL7]
            tx_ie_q       <= 1'b0;
            rx_ie_q       <= 1'b0;
            tx_toggle_q   <= 1'b0;
            tx_en_q       <= 1'b0;
            rx_en_q       <= 1'b0;
            tx_bytes_q    <= `USBH_RST_COUNT; // [RL16]
            ep1_force_stall_q      <= 1'b0;
            pending_q     <= 1'b0;
            bitmap_q      <= `USBH_RST_BITMAP; // [RL19]
        end else if (i_ce) begin
            if (wr_ha) begin
                hub_address_q <= wd[6:0];
            end
            if (wr_i0) begin
                tx_ie_q <= wd[`USBH_I0_TX_IE];
                rx_ie_q <= wd[`USBH_I0_RX_IE];
            end
            if (wr_c0) begin
                tx_toggle_q <= wd[`USBH_C0_TOGGLE]; // [RL14]
                tx_en_q     <= wd[`USBH_C0_TX_EN];
                rx_en_q     <= wd[`USBH_C0_RX_EN];
                tx_bytes_q  <= wd[3:0];
            end
            if (wr_c1) begin
                ep1_force_stall_q  <= wd[`USBH_C1_STALL];
                pending_q <= wd[`USBH_C1_PENDING]; // [RL18]
                bitmap_q  <= wd[5:0]; // [RL19]
            end
        end
    end

    // A SETUP token clears the stall even against a same-cycle write
    always_ff @(posedge i_clk_sys) begin
        if (mod_rst) begin
            ep0_force_stall_q <= 1'b0;
        end else if (i_ce) begin
            ep0_force_stall_q <= setup_hit ? 1'b0 : (wr_c0 ? wd[`USBH_C0_STALL] : ep0_force_stall_q); // [RL15]
        end
    end

    // Chip-side outputs
    always_ff @(posedge i_clk_sys) begin
        if (i_por) begin
            chip_reset_q <= 1'b0;
            enable_out_q <= 1'b0;
            irq_q        <= 1'b0;
        end else if (i_ce) begin
            chip_reset_q <= bus_reset_evt; // [RL1]
            enable_out_q <= module_enable_q; // [RL5]
            irq_q        <= (tx_done_q && tx_ie_q) || (rx_done_q && rx_ie_q); // [RL13]
        end
    end

    usbh_ep_resp u_resp (
        .i_clk_sys (i_clk_sys),
        .i_rst     (mod_rst),
        .i_ce      (i_ce),
        .i_hit0    (hit0),
        .i_hit1    (hit1),
        .i_tok     (i_tok_pid),
        .i_ep0_force_stall  (ep0_force_stall_q),
        .i_tx_en   (tx_en_q),
        .i_tx_done (tx_done_q),
        .i_rx_en   (rx_en_q),
        .i_rx_done (rx_done_q),
        .i_ep1_force_stall  (ep1_force_stall_q),
        .i_pending (pending_q),
        .o_valid   (o_rsp_valid),
        .o_rsp     (o_rsp),
        .o_ep1     (rsp_ep1)
    );

    assign o_wb_ack        = ack_q;
    assign o_wb_dat        = {24'h000000, rdat_q};
    assign o_rsp_data1     = tx_toggle_q; // [RL14]
    assign o_rsp_bytes     = tx_bytes_q; // [RL16]
    assign o_change_bitmap = bitmap_q; // [RL19]
    assign o_chip_reset    = chip_reset_q;
    assign o_regulator_en  = enable_out_q;
    assign o_xcvr_en       = enable_out_q;
    assign o_irq           = irq_q;

    // Rule checks
    chk_bus_reset_flag_set: assert property (@(posedge i_clk_sys) disable iff (i_por) // [RL1]
        i_ce && bus_reset_evt |=> bus_reset_flag_q && o_chip_reset)
        else $error("bus reset did not set flag and chip reset");
    chk_bus_reset_flag_keep: assert property (@(posedge i_clk_sys) disable iff (i_por) // [RL2]
        i_ce && bus_reset_flag_q && !(wr_ts && wd[`USBH_TS_BUS_RESET]) |=> bus_reset_flag_q)
        else $error("bus reset flag lost without clear");
    chk_lock_clear: assert property (@(posedge i_clk_sys) disable iff (mod_rst) // [RL4]
        i_ce && wr_ts && wd[`USBH_TS_FRAME_LOCK] && !i_frame_locked |=> !frame_lock_flag_q)
        else $error("frame lock clear ignored");
    chk_zero_noclr: assert property (@(posedge i_clk_sys) disable iff (mod_rst) // [RL3]
        i_ce && wr_i0 && !wd[`USBH_I0_TX_CLR] && tx_done_q |=> tx_done_q)
        else $error("zero write cleared transmit done");
    chk_disable_mute: assert property (@(posedge i_clk_sys) disable iff (mod_rst) // [RL5]
        i_ce && !module_enable_q ##1 i_ce |-> !o_rsp_valid && !o_regulator_en)
        else $error("disabled module answered or powered");
    chk_enable_keep: assert property (@(posedge i_clk_sys) disable iff (i_por) // [RL6]
        module_enable_q |=> module_enable_q)
        else $error("module enable dropped");
    chk_addr_reset: assert property (@(posedge i_clk_sys) // [RL7]
        i_sys_rst |=> hub_address_q == `USBH_RST_ADDR)
        else $error("address not cleared by reset");
    chk_tx_done_set: assert property (@(posedge i_clk_sys) disable iff (mod_rst) // [RL8]
        i_ce && i_ep0_tx_acked |=> tx_done_q)
        else $error("transmit done not set after ack");
    chk_in_nak: assert property (@(posedge i_clk_sys) disable iff (mod_rst) // [RL9]
        i_ce && hit0 && i_tok_pid == TOK_IN && !ep0_force_stall_q && (!tx_en_q || tx_done_q)
        |=> o_rsp == RSP_NAK)
        else $error("endpoint 0 IN not refused");
    chk_out_nak: assert property (@(posedge i_clk_sys) disable iff (mod_rst) // [RL11]
        i_ce && hit0 && i_tok_pid == TOK_OUT && !ep0_force_stall_q && (!rx_en_q || rx_done_q)
        |=> o_rsp == RSP_NAK)
        else $error("endpoint 0 OUT not refused");
    chk_irq_req: assert property (@(posedge i_clk_sys) disable iff (i_por || !i_ce) // [RL13]
        (tx_done_q && tx_ie_q) || (rx_done_q && rx_ie_q) |=> o_irq)
        else $error("interrupt request missing");
    chk_setup_unstall: assert property (@(posedge i_clk_sys) disable iff (mod_rst) // [RL15]
        i_ce && setup_hit |=> !ep0_force_stall_q)
        else $error("SETUP left stall set");
    chk_ep1_stall: assert property (@(posedge i_clk_sys) disable iff (mod_rst) // [RL17]
        i_ce && hit1 && i_tok_pid == TOK_IN && ep1_force_stall_q |=> o_rsp == RSP_STALL && rsp_ep1)
        else $error("endpoint 1 stall not sent");

    chk_rx_done_set: assert property (@(posedge i_clk_sys) disable iff (mod_rst) // [RL10]
        i_ce && i_ep0_rx_accepted |=> rx_done_q)
        else $error("receive done not set");
    chk_ep1_nak: assert property (@(posedge i_clk_sys) disable iff (mod_rst) // [RL18]
        i_ce && hit1 && i_tok_pid == TOK_IN && !ep1_force_stall_q && !pending_q |=> o_rsp == RSP_NAK)
        else $error("endpoint 1 poll not refused");

    cov_ep0_data: cover property (@(posedge i_clk_sys) o_rsp_valid && o_rsp == RSP_DATA);
    cov_ep0_ack: cover property (@(posedge i_clk_sys) o_rsp_valid && o_rsp == RSP_ACK);
    cov_bus_reset: cover property (@(posedge i_clk_sys) bus_reset_evt);
    cov_ep1_data: cover property (@(posedge i_clk_sys) rsp_ep1 && o_rsp == RSP_DATA);
    cov_ep0_stall: cover property (@(posedge i_clk_sys) o_rsp_valid && o_rsp == RSP_STALL);
endmodule

// ---- dv/usbh_host_model.sv ----
// Host controller model driving the root port lines and serial-engine events
module usbh_host_model (
    // Clock
    input  wire logic  i_clk_sys,
    // Root port lines
    output logic       o_dp,
    output logic       o_dm,
    // Token and handshake events
    output logic       o_tok_valid,
    output logic [1:0] o_tok_pid,
    output logic [6:0] o_tok_addr,
    output logic [3:0] o_tok_ep,
    output logic [4:0] o_evt
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {o_dp, o_dm} = 2'b10;
        {o_tok_valid, o_tok_pid, o_tok_addr, o_tok_ep, o_evt} = 19'h00000;
    end
    // One-cycle token; fields are scrambled once it drops so stale values never pass
    task automatic token(input logic [1:0] p, input logic [6:0] a, input logic [3:0] e);
        @(posedge i_clk_sys);
        {o_tok_valid, o_tok_pid, o_tok_addr, o_tok_ep} <= {1'b1, p, a, e};
        @(posedge i_clk_sys);
        {o_tok_valid, o_tok_pid, o_tok_addr, o_tok_ep} <= {1'b0, ~p, ~a, ~e};
    endtask
    // Event pulse: b4 EOF2, b3 EOP, b2 host ACKed data, b1 we ACKed data, b0 lock
    task automatic ev(input logic [4:0] m);
        @(posedge i_clk_sys);
        o_evt <= m;
        @(posedge i_clk_sys);
        o_evt <= 5'h00;
    endtask
    // Bus reset: both lines low, then back to idle J
    task automatic se0(input int n);
        @(posedge i_clk_sys);
        {o_dp, o_dm} <= 2'b00;
        repeat (n) @(posedge i_clk_sys);
        {o_dp, o_dm} <= 2'b10;
    endtask
endmodule

// ---- dv/usb_hub_endpoint_control_test.sv ----
// Self-checking bench for the hub status and control block
module usb_hub_endpoint_control_test
    import usbh_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, por = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [6:0]  hub_adr = 7'h00, ta;
    logic [1:0]  pid;
    logic [3:0]  tep, bytes;
    logic [4:0]  evt;
    logic [5:0]  bitmap;
    logic        ack, rsp_valid, data1, chip_rst, reg_en, xcvr_en, irq, dp, dm, tv, ce = 1'b1;
    usbh_rsp_t   rsp;
    int          mismatches = 0, checks = 0, n;
    always #50 clk_sys = ~clk_sys;
    usbh_host_model host (.i_clk_sys(clk_sys), .o_dp(dp), .o_dm(dm), .o_tok_valid(tv),
        .o_tok_pid(pid), .o_tok_addr(ta), .o_tok_ep(tep), .o_evt(evt));
    usbh_ep_ctrl uut (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_por(por), .i_ce(ce),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_dp(dp), .i_dm(dm),
        .i_tok_valid(tv), .i_tok_pid(pid), .i_tok_addr(ta), .i_tok_ep(tep),
        .i_ep0_tx_acked(evt[2]), .i_ep0_rx_accepted(evt[1]), .i_frame_locked(evt[0]),
        .i_eof2_evt(evt[4]), .i_eop_evt(evt[3]), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
        .o_rsp_data1(data1), .o_rsp_bytes(bytes), .o_change_bitmap(bitmap),
        .o_chip_reset(chip_rst), .o_regulator_en(reg_en), .o_xcvr_en(xcvr_en), .o_irq(irq));
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", s, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r);
        int k;
        k = 0;
        @(posedge clk_sys);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h000000, d};
        do begin
            @(posedge clk_sys);
            k++;
        end while (ack !== 1'b1 && k < 20);
        r = rdat[7:0];
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1) begin
            mismatches++;
            test_done();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, a, d, r);
    endtask
    task automatic rdm(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        logic [7:0] r;
        wb(1'b0, a, 8'h00, r);
        chk($sformatf("reg %0h", a), r & m, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rdm(a, e, 8'hff);
    endtask
    task automatic tok(input logic [1:0] p, input logic [3:0] e, input logic v, input usbh_rsp_t x);
        host.token(p, hub_adr, e);
        #1;
        chk("rsp_valid", rsp_valid, v);
        if (v) chk("rsp", rsp, x);
    endtask
    task automatic t_reset_and_enable();
        rd(8'h04, 8'h00);
        rd(8'h0c, 8'h00);
        rd(8'h10, 8'h00);
        rd(8'h14, 8'h00);
        chk("regulator off", {reg_en, xcvr_en}, 2'b00);
        tok(TOK_IN, 4'h0, 1'b0, RSP_NONE);
        wr(8'h04, 8'h85);
        wr(8'h04, 8'h05);
        rd(8'h04, 8'h85);
        chk("regulator on", {reg_en, xcvr_en}, 2'b11);
        hub_adr = 7'h06;
        tok(TOK_IN, 4'h0, 1'b0, RSP_NONE);
        hub_adr = 7'h05;
    endtask
    task automatic t_ep0();
        tok(TOK_IN, 4'h0, 1'b1, RSP_NAK);
        wr(8'h0c, 8'ha3);
        tok(TOK_IN, 4'h0, 1'b1, RSP_DATA);
        chk("data1", data1, 1'b1);
        chk("bytes", bytes, 4'h3);
        wr(8'h08, 8'h08);
        host.ev(5'h04);
        rd(8'h08, 8'h88);
        chk("irq tx", irq, 1'b1);
        tok(TOK_IN, 4'h0, 1'b1, RSP_NAK);
        rd(8'h0c, 8'ha3);
        wr(8'h08, 8'h08);
        rd(8'h08, 8'h88);
        wr(8'h08, 8'h06);
        rd(8'h08, 8'h04);
        chk("irq off", irq, 1'b0);
        tok(TOK_OUT, 4'h0, 1'b1, RSP_NAK);
        wr(8'h0c, 8'hb3);
        tok(TOK_OUT, 4'h0, 1'b1, RSP_ACK);
        host.ev(5'h02);
        rd(8'h08, 8'h44);
        chk("irq rx", irq, 1'b1);
        tok(TOK_OUT, 4'h0, 1'b1, RSP_NAK);
        wr(8'h08, 8'h01);
        rd(8'h08, 8'h00);
        wr(8'h0c, 8'hf3);
        host.ev(5'h04);
        tok(TOK_IN, 4'h0, 1'b1, RSP_STALL);
        tok(TOK_OUT, 4'h0, 1'b1, RSP_STALL);
        tok(TOK_SETUP, 4'h0, 1'b1, RSP_ACK);
        rd(8'h0c, 8'hb3);
    endtask
    task automatic t_ep1_and_frame();
        wr(8'h10, 8'h21);
        tok(TOK_IN, 4'h1, 1'b1, RSP_NAK);
        wr(8'h10, 8'h61);
        tok(TOK_IN, 4'h1, 1'b1, RSP_DATA);
        chk("bitmap", bitmap, 6'h21);
        wr(8'h10, 8'he1);
        ce <= 1'b0;
        tok(TOK_IN, 4'h1, 1'b0, RSP_NONE);
        @(posedge clk_sys);
        ce <= 1'b1;
        tok(TOK_IN, 4'h1, 1'b1, RSP_STALL);
        wr(8'h00, 8'h0f);
        host.ev(5'h19);
        tok(TOK_SOF, 4'h0, 1'b0, RSP_NONE);
        rd(8'h00, 8'h4e);
        wr(8'h00, 8'h40);
        rd(8'h00, 8'h0e);
        wr(8'h00, 8'h0e);
        rd(8'h00, 8'h00);
    endtask
    task automatic t_bus_reset();
        n = 0;
        fork
            host.se0(40);
            while (chip_rst !== 1'b1 && n < 60) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
        join
        chk("chip reset", n < 60, 1'b1);
        if (n >= 60) test_done();
        rdm(8'h00, 8'h80, 8'h80);
        rd(8'h04, 8'h80);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdm(8'h00, 8'h80, 8'h80);
        wr(8'h00, 8'h80);
        rdm(8'h00, 8'h00, 8'h80);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        {sys_rst, por} <= 2'b00;
        t_reset_and_enable();
        t_ep0();
        t_ep1_and_frame();
        t_bus_reset();
        test_done();
    end
endmodule
